// *** twe_pkg.sv ***
package twe_pkg;

	// System clock and self-timed write duration
	localparam int CLK_HZ     = 40_000_000;
	localparam int WR_TIME_MS = 5;
	// Longest time, so the cycle count rounds down
	localparam int WR_CYCLES  = WR_TIME_MS * (CLK_HZ / 1000);

	// Array organisation
	localparam int ADDR_W      = 16;
	localparam int PAGE_IDX_W  = 7;
	localparam int PAGE_BYTES  = 128;
	localparam int BYTE_W      = 8;
	localparam int STRAP_W     = 3;

	// Fixed device-type pattern in the top nibble of the device address
	localparam logic [3:0] DEV_TYPE = 4'hA;

	// Bit counter milestones: eight data rises, then the ninth (acknowledge) rise
	localparam logic [3:0] CNT_BYTE = 4'h8;
	localparam logic [3:0] CNT_ACK  = 4'h9;
	localparam logic [3:0] CNT_LAST = 4'h7;

	// Synchroniser lane layout: scl, sda, protect, three straps
	localparam int SYNC_W     = 6;
	localparam int LANE_SCL   = 0;
	localparam int LANE_SDA   = 1;
	localparam int LANE_WP    = 2;
	localparam int LANE_STRAP = 3;

	// Page byte count saturation value
	localparam logic [7:0] PAGE_FULL = 8'h80;

	typedef enum logic [2:0] {
		ST_STANDBY,
		ST_DEV,
		ST_ADDR_HI,
		ST_ADDR_LO,
		ST_WDATA,
		ST_READ,
		ST_COMMIT,
		ST_WRITE_WAIT
	} twe_state_e;

endpackage

// *** twe_sync.sv ***
`timescale 1ns/100ps
module twe_sync #(
	parameter int W = 1
) (
	clk,
	rstn,
	din,
	dout
);
	input  wire logic         clk;
	input  wire logic         rstn;
	input  wire logic [W-1:0] din;
	output logic      [W-1:0] dout;

	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;

	// Three-stage chain; only the second stage reads the first
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end
		else
		begin
			s1_q <= din;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// A lane takes a new level only once stages two and three agree
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			dout <= '0;
		else
			dout <= (s2_q & ~(s2_q ^ s3_q)) | (dout & (s2_q ^ s3_q));
	end

endmodule

// *** twe_target.sv ***
// Notes on behaviour
// - SDA changes only while SCL low; changes with SCL high are start or stop.
// - SDA falling with SCL high is a start; device restarts transfer.
// - SDA rising with SCL high is a stop; after a read, go standby.
// - Bytes are eight bits; device pulls SDA low on the ninth clock.
// - Standby at power-up and after stop once internal work completes.
// - Start, nine clocks, start, stop leaves device ready for a fresh transfer.
// - Device address upper nibble must equal the fixed device-type pattern.
// - Next three address bits must match the three strap inputs.
// - Last device address bit: one reads, zero writes.
// - Matching address is acknowledged; mismatch gets no acknowledge and standby.
// - Protect input high blocks every write to the array.
// - Byte write: two address bytes, one data byte, each acknowledged, then stop.
// - Stop after write data starts self-timed write, at most 5 ms, inputs ignored.
// - Page write accepts up to 127 more data bytes, each acknowledged.
// - Writes increment only the low seven address bits, wrapping within the page.
// - Polls during internal write are acknowledged only after it finishes.
// - Address counter holds last address plus one; reads wrap at memory end.
// - Current-address read shifts out byte at counter after address acknowledge.
// - Sequential read continues while controller acknowledges; ends on no-ack and stop.
// - Sixteen-bit word address; 512 pages of 128 bytes.
// - Sample SDA on rising SCL; change outgoing SDA after falling SCL.
// - Device only pulls SDA low or releases it.
`timescale 1ns/100ps
module twe_target
	import twe_pkg::*;
#(
	parameter int WR_CYCLES = twe_pkg::WR_CYCLES
) (
	clk,
	rstn,
	scl_i,
	sda_i,
	sda_o,
	sda_oe,
	chip_select_straps,
	write_protect,
	mem_addr,
	mem_wdata,
	mem_we,
	mem_re,
	mem_rdata,
	standby
);
	input  wire logic                          clk;
	input  wire logic                          rstn;
	input  wire logic                          scl_i;
	input  wire logic                          sda_i;
	output logic                               sda_o;
	output logic                               sda_oe;
	input  wire logic [twe_pkg::STRAP_W-1:0]   chip_select_straps;
	input  wire logic                          write_protect;
	output logic      [twe_pkg::ADDR_W-1:0]    mem_addr;
	output logic      [twe_pkg::BYTE_W-1:0]    mem_wdata;
	output logic                               mem_we;
	output logic                               mem_re;
	input  wire logic [twe_pkg::BYTE_W-1:0]    mem_rdata;
	output logic                               standby;

	import twe_pkg::*;

	logic [SYNC_W-1:0]     sync_s;
	logic                  scl_s;
	logic                  sda_s;
	logic                  wp_s;
	logic [STRAP_W-1:0]    straps_s;
	logic                  scl_p_q;
	logic                  sda_p_q;
	logic                  scl_rise;
	logic                  scl_fall;
	logic                  start_det;
	logic                  stop_det;
	twe_state_e            state_q;
	logic [3:0]            cnt_q;
	logic [BYTE_W-1:0]     rx_q;
	logic [BYTE_W-1:0]     tx_q;
	logic                  rw_q;
	logic                  mack_q;
	logic [BYTE_W-1:0]     addr_hi_q;
	logic [ADDR_W-1:0]     ptr_q;
	logic [BYTE_W-1:0]     page_buf [PAGE_BYTES];
	logic [PAGE_IDX_W-1:0] wstart_q;
	logic [7:0]            wcount_q;
	logic [PAGE_IDX_W-1:0] cidx_q;
	logic [7:0]            remain_q;
	logic [31:0]           wait_q;
	logic [1:0]            ld_q;
	logic                  busy;
	logic                  rx_state;
	logic                  byte_end;
	logic                  ack_end;
	logic                  dev_match;
	logic                  rd_issue;
	logic                  commit_go;
	logic                  wait_done;

	// Pins cross into the clock domain through one shared synchroniser
	twe_sync #(
		.W (SYNC_W)
	) u_sync (
		.clk  (clk),
		.rstn (rstn),
		.din  ({chip_select_straps, write_protect, sda_i, scl_i}),
		.dout (sync_s)
	);

	assign scl_s    = sync_s[LANE_SCL];
	assign sda_s    = sync_s[LANE_SDA];
	assign wp_s     = sync_s[LANE_WP];
	assign straps_s = sync_s[LANE_STRAP +: STRAP_W];

	// Previous line levels for edge detection
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			scl_p_q <= 1'b0;
			sda_p_q <= 1'b0;
		end
		else
		begin
			scl_p_q <= scl_s;
			sda_p_q <= sda_s;
		end
	end

	// Bus events; SDA moving while SCL stays high is start or stop
	assign scl_rise  = scl_s & ~scl_p_q;
	assign scl_fall  = ~scl_s & scl_p_q;
	assign start_det = scl_s & scl_p_q & sda_p_q & ~sda_s;
	assign stop_det  = scl_s & scl_p_q & ~sda_p_q & sda_s;

	// Protocol qualifiers
	assign busy      = (state_q == ST_COMMIT) || (state_q == ST_WRITE_WAIT);
	assign rx_state  = (state_q == ST_DEV) || (state_q == ST_ADDR_HI) ||
			   (state_q == ST_ADDR_LO) || (state_q == ST_WDATA);
	assign byte_end  = scl_fall && (cnt_q == CNT_BYTE);
	assign ack_end   = scl_fall && (cnt_q == CNT_ACK);
	assign dev_match = (rx_q[7:4] == DEV_TYPE) && (rx_q[3:1] == straps_s);
	assign rd_issue  = ((state_q == ST_DEV) && ack_end && rw_q) ||
			   ((state_q == ST_READ) && ack_end && mack_q);
	// The rise just before a clean stop has already counted one bit
	assign commit_go = stop_det && (state_q == ST_WDATA) && (cnt_q == 4'h1) &&
			   (wcount_q != 8'h00) && !wp_s;
	assign wait_done = (state_q == ST_WRITE_WAIT) && (wait_q == 32'(WR_CYCLES - 1));

	// Transfer sequencer; busy states ignore the bus entirely
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			state_q <= ST_STANDBY;
		else if (busy)
		begin
			if (state_q == ST_COMMIT && remain_q == 8'h00)
				state_q <= ST_WRITE_WAIT;
			else if (wait_done)
				state_q <= ST_STANDBY;
		end
		else if (start_det)
			state_q <= ST_DEV;
		else if (stop_det)
			state_q <= commit_go ? ST_COMMIT : ST_STANDBY;
		else
		begin
			unique case (state_q)
				ST_DEV:
				begin
					if (byte_end && !dev_match)
						state_q <= ST_STANDBY;
					else if (ack_end)
						state_q <= rw_q ? ST_READ : ST_ADDR_HI;
				end
				ST_ADDR_HI:
					if (ack_end)
						state_q <= ST_ADDR_LO;
				ST_ADDR_LO:
					if (ack_end)
						state_q <= ST_WDATA;
				ST_READ:
					if (ack_end && !mack_q)
						state_q <= ST_STANDBY;
				ST_STANDBY, ST_WDATA, ST_COMMIT, ST_WRITE_WAIT:
					state_q <= state_q;
			endcase
		end
	end

	// Bit counter: advances on rises, eight data bits then the acknowledge bit
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			cnt_q <= 4'h0;
		else if (busy || start_det || ld_q[1])
			cnt_q <= 4'h0;
		else if (ack_end)
			cnt_q <= 4'h0;
		else if (scl_rise && cnt_q < CNT_ACK)
			cnt_q <= cnt_q + 4'h1;
	end

	// Incoming bits are taken on rising SCL, most significant first
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			rx_q   <= 8'h00;
			mack_q <= 1'b0;
		end
		else if (scl_rise)
		begin
			if (cnt_q < CNT_BYTE)
				rx_q <= {rx_q[6:0], sda_s};
			if (cnt_q == CNT_BYTE)
				mack_q <= ~sda_s;
		end
	end

	// Direction bit of an accepted device address
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			rw_q <= 1'b0;
		else if (state_q == ST_DEV && byte_end)
			rw_q <= rx_q[0];
	end

	// Read data fetch pipeline: issue, array latch, capture
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			ld_q <= 2'b00;
		else
			ld_q <= {ld_q[0] && !start_det && !stop_det, rd_issue};
	end

	// Outgoing shift register; changes only after falling SCL
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			tx_q <= 8'h00;
		else if (ld_q[1])
			tx_q <= mem_rdata;
		else if (state_q == ST_READ && scl_fall && cnt_q != 4'h0 && cnt_q <= CNT_LAST)
			tx_q <= {tx_q[6:0], 1'b0};
	end

	// Open-drain pull-down: acknowledge slots and zero read bits only
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			sda_oe <= 1'b0;
		else if (busy || start_det || stop_det)
			sda_oe <= 1'b0;
		else if (rx_state && byte_end)
			sda_oe <= (state_q != ST_DEV) || dev_match;
		else if (ld_q[1] && state_q == ST_READ)
			sda_oe <= ~mem_rdata[7];
		else if (state_q == ST_READ && scl_fall && cnt_q != 4'h0 && cnt_q <= CNT_LAST)
			sda_oe <= ~tx_q[6];
		else if (scl_fall && (cnt_q == CNT_BYTE || cnt_q == CNT_ACK))
			sda_oe <= 1'b0;
	end

	// The data output is only ever low; the enable alone drives the line
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			sda_o <= 1'b0;
		else
			sda_o <= 1'b0;
	end

	// Word address: high byte, then low byte loads the counter
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			addr_hi_q <= 8'h00;
		else if (state_q == ST_ADDR_HI && byte_end)
			addr_hi_q <= rx_q;
	end

	// Address counter, kept between operations
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			ptr_q <= 16'h0000;
		else if (state_q == ST_ADDR_LO && byte_end)
			ptr_q <= {addr_hi_q, rx_q};
		else if (state_q == ST_WDATA && byte_end)
			ptr_q[PAGE_IDX_W-1:0] <= ptr_q[PAGE_IDX_W-1:0] + 7'h01;
		else if (rd_issue)
			ptr_q <= ptr_q + 16'h0001;
	end

	// Page staging buffer holds data until a clean stop
	always_ff @(posedge clk)
	begin
		if (state_q == ST_WDATA && byte_end)
			page_buf[ptr_q[PAGE_IDX_W-1:0]] <= rx_q;
	end

	// Page extent: first index and saturating byte count
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			wstart_q <= 7'h00;
			wcount_q <= 8'h00;
		end
		else if (state_q == ST_ADDR_LO && byte_end)
		begin
			wstart_q <= rx_q[PAGE_IDX_W-1:0];
			wcount_q <= 8'h00;
		end
		else if (state_q == ST_WDATA && byte_end && wcount_q != PAGE_FULL)
			wcount_q <= wcount_q + 8'h01;
	end

	// Commit walker: replays the staged page into the array
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			cidx_q   <= 7'h00;
			remain_q <= 8'h00;
		end
		else if (commit_go)
		begin
			cidx_q   <= wstart_q;
			remain_q <= wcount_q;
		end
		else if (state_q == ST_COMMIT && remain_q != 8'h00)
		begin
			cidx_q   <= cidx_q + 7'h01;
			remain_q <= remain_q - 8'h01;
		end
	end

	// Self-timed write interval
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			wait_q <= 32'h0000_0000;
		else if (state_q == ST_WRITE_WAIT)
			wait_q <= wait_q + 32'h0000_0001;
		else
			wait_q <= 32'h0000_0000;
	end

	// Array port: read strobes and protected write strobes
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			mem_addr  <= 16'h0000;
			mem_wdata <= 8'h00;
			mem_we    <= 1'b0;
			mem_re    <= 1'b0;
		end
		else
		begin
			mem_we <= 1'b0;
			mem_re <= 1'b0;
			if (rd_issue)
			begin
				mem_re   <= 1'b1;
				mem_addr <= ptr_q;
			end
			else if (state_q == ST_COMMIT && remain_q != 8'h00)
			begin
				mem_we    <= ~wp_s;
				mem_addr  <= {ptr_q[ADDR_W-1:PAGE_IDX_W], cidx_q};
				mem_wdata <= page_buf[cidx_q];
			end
		end
	end

	// Low-power indication
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			standby <= 1'b1;
		else
			standby <= (state_q == ST_STANDBY);
	end

	property p_ack_ninth;
		@(posedge clk) disable iff (!rstn)
		((state_q == ST_ADDR_HI || state_q == ST_ADDR_LO || state_q == ST_WDATA)
			&& cnt_q == CNT_ACK) |-> sda_oe;
	endproperty
	a_ack_ninth: assert property (p_ack_ninth) else $error("no acknowledge on ninth bit");

	property p_start_begins;
		@(posedge clk) disable iff (!rstn)
		(start_det && !busy) |=> (state_q == ST_DEV && cnt_q == 4'h0);
	endproperty
	a_start_begins: assert property (p_start_begins) else $error("start not taken");

	property p_read_stop;
		@(posedge clk) disable iff (!rstn)
		(stop_det && !busy && !commit_go) |=> (state_q == ST_STANDBY) ##1 standby;
	endproperty
	a_read_stop: assert property (p_read_stop) else $error("read stop not standby");

	property p_nomatch;
		@(posedge clk) disable iff (!rstn)
		(state_q == ST_DEV && byte_end && !dev_match && !start_det && !stop_det)
			|=> (state_q == ST_STANDBY && !sda_oe);
	endproperty
	a_nomatch: assert property (p_nomatch) else $error("mismatch acknowledged");

	property p_protect;
		@(posedge clk) disable iff (!rstn)
		wp_s |=> !mem_we;
	endproperty
	a_protect: assert property (p_protect) else $error("write under protect");

	property p_busy_silent;
		@(posedge clk) disable iff (!rstn)
		$past(busy) && busy |-> !sda_oe && !mem_re;
	endproperty
	a_busy_silent: assert property (p_busy_silent) else $error("response while busy");

	property p_write_bound;
		@(posedge clk) disable iff (!rstn)
		(state_q == ST_WRITE_WAIT) |-> (wait_q < 32'(WR_CYCLES));
	endproperty
	a_write_bound: assert property (p_write_bound) else $error("write cycle too long");

	property p_page_wrap;
		@(posedge clk) disable iff (!rstn)
		(state_q == ST_WDATA && byte_end && !start_det && !stop_det) |=>
			$stable(ptr_q[ADDR_W-1:PAGE_IDX_W]) &&
			(ptr_q[PAGE_IDX_W-1:0] == $past(ptr_q[PAGE_IDX_W-1:0]) + 7'h01);
	endproperty
	a_page_wrap: assert property (p_page_wrap) else $error("page address wrong");

	property p_abort;
		@(posedge clk) disable iff (!rstn)
		(stop_det && state_q == ST_WDATA && cnt_q > 4'h1) |=> state_q == ST_STANDBY;
	endproperty
	a_abort: assert property (p_abort) else $error("partial byte committed");

	property p_read_inc;
		@(posedge clk) disable iff (!rstn)
		rd_issue |=> mem_re && (ptr_q == mem_addr + 16'h0001);
	endproperty
	a_read_inc: assert property (p_read_inc) else $error("read counter wrong");

endmodule

// *** twe_ctrl_model.sv ***
`timescale 1ns/100ps
module twe_ctrl_model (
	clk,
	sda,
	scl,
	sda_low
);
	input  wire logic clk;
	input  wire logic sda;
	output logic      scl;
	output logic      sda_low;
	int               stretch;

	// Bus parks with the clock high and data released
	initial
	begin
		scl = 1'h1;
		sda_low = 1'h0;
		stretch = 0;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	// Data moves only while the clock is low; the low phase outlasts the first read bit
	task automatic low_set(input logic pull);
		scl <= 1'h0;
		tick(7 + stretch);
		sda_low <= pull;
		tick(1);
		scl <= 1'h1;
	endtask

	// One clock pulse, sampled late in the high phase
	task automatic bit_cyc(input logic b, output logic s);
		low_set(~b);
		tick(3);
		s = sda;
		tick(1);
	endtask

	// Start, also used as a repeated start or a poll
	task automatic start();
		low_set(1'h0);
		tick(4);
		sda_low <= 1'h1;
		tick(4);
	endtask

	// Stop leaves the bus idle
	task automatic stop();
		low_set(1'h1);
		tick(4);
		sda_low <= 1'h0;
		tick(4);
	endtask

	// Byte out, most significant bit first, then the acknowledge slot
	task automatic put(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_cyc(d[i], s);
		bit_cyc(1'h1, ack);
	endtask

	// Byte in; more keeps a sequential read going
	task automatic get(input logic more, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--)
		begin
			bit_cyc(1'h1, s);
			d[i] = s;
		end
		bit_cyc(~more, s);
	endtask
endmodule

// *** twe_target_tb_top.sv ***
`timescale 1ns/100ps
module twe_target_tb_top;
	import twe_pkg::*;
	localparam int WRC = 400;
	logic        clk;
	logic        rstn;
	logic        scl;
	logic        sda_low;
	wire         sda;
	logic        sda_o;
	logic        sda_oe;
	logic [2:0]  straps;
	logic        wp;
	logic [15:0] mem_addr;
	logic [7:0]  mem_wdata;
	logic        mem_we;
	logic        mem_re;
	logic [7:0]  mem_rdata;
	logic        standby;
	logic [7:0]  mem_q [0:65535];
	logic [7:0]  exp_q [0:65535];
	int          errors;
	int          check_count;
	int          we_cnt;
	logic [31:0] rs;

	// Open-drain data line with pull-up
	assign sda = ~(sda_low | (sda_oe & ~sda_o));

	twe_ctrl_model ctl_u (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));

	twe_target #(.WR_CYCLES(WRC)) dut_u (
		.clk               (clk),
		.rstn              (rstn),
		.scl_i             (scl),
		.sda_i             (sda),
		.sda_o             (sda_o),
		.sda_oe            (sda_oe),
		.chip_select_straps(straps),
		.write_protect     (wp),
		.mem_addr          (mem_addr),
		.mem_wdata         (mem_wdata),
		.mem_we            (mem_we),
		.mem_re            (mem_re),
		.mem_rdata         (mem_rdata),
		.standby           (standby)
	);

	initial
	begin
		clk = 1'h0;
		forever #12.5 clk = ~clk;
	end

	// Array stand-in: synchronous read, one write per pulse
	always @(posedge clk)
	begin
		if (mem_we)
		begin
			mem_q[mem_addr] <= mem_wdata;
			we_cnt <= we_cnt + 1;
		end
		if (mem_re)
			mem_rdata <= mem_q[mem_addr];
	end

	function automatic logic [31:0] nxt();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction

	function automatic logic [7:0] dev(input logic rw);
		return {DEV_TYPE, straps, rw};
	endfunction

	task automatic complete_run();
		$display("checks=%0d errors=%0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] expv);
		check_count++;
		if (seen !== expv)
		begin
			errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, expv);
		end
	endtask

	// Write-direction header: device byte and both address bytes
	task automatic hdr(input logic [15:0] a);
		logic ack;
		ctl_u.start();
		ctl_u.put(dev(1'h0), ack);
		check(ack, 1'h0);
		ctl_u.put(a[15:8], ack);
		check(ack, 1'h0);
		ctl_u.put(a[7:0], ack);
		check(ack, 1'h0);
	endtask

	// Random read of n bytes, then no-acknowledge and stop
	task automatic rd_seq(input logic [15:0] a, input int n);
		logic       ack;
		logic [7:0] d;
		hdr(a);
		ctl_u.start();
		ctl_u.put(dev(1'h1), ack);
		check(ack, 1'h0);
		for (int i = 0; i < n; i++)
		begin
			ctl_u.get(i < n - 1, d);
			check(d, exp_q[a + i[15:0]]);
		end
		ctl_u.stop();
	endtask

	// Write n random bytes; mirror them unless protected
	task automatic wr_page(input logic [15:0] a, input int n);
		logic       ack;
		logic [7:0] d;
		hdr(a);
		for (int i = 0; i < n; i++)
		begin
			d = nxt() >> 5;
			ctl_u.put(d, ack);
			check(ack, 1'h0);
			if (!wp)
				exp_q[{a[15:7], a[6:0] + i[6:0]}] = d;
		end
		ctl_u.stop();
	endtask

	// Poll until the self-timed write is over, bounded
	task automatic wait_idle();
		logic ack;
		ack = 1'h1;
		for (int k = 0; k < 20 && ack !== 1'h0; k++)
		begin
			ctl_u.start();
			ctl_u.put(dev(1'h0), ack);
			ctl_u.stop();
		end
		if (ack !== 1'h0)
		begin
			errors++;
			complete_run();
		end
	endtask

	initial
	begin
		logic        ack;
		logic [7:0]  d;
		logic [15:0] a;
		int          n;
		int          we0;
		rstn = 1'h0;
		straps = 3'h0;
		wp = 1'h0;
		mem_rdata = 8'h00;
		rs = 89;
		errors = 0;
		check_count = 0;
		we_cnt = 0;
		for (int i = 0; i < 65536; i++)
		begin
			mem_q[i] = i[7:0] ^ i[15:8];
			exp_q[i] = i[7:0] ^ i[15:8];
		end
		repeat (8) @(posedge clk);
		check(standby, 1'h1);
		check(sda_oe, 1'h0);
		rstn <= 1'h1;
		straps <= nxt() >> 7;
		repeat (12) @(posedge clk);
		// Each corrupted device address bit from 1 to 7 goes unanswered
		for (int k = 1; k < 8; k++)
		begin
			ctl_u.start();
			ctl_u.put(dev(1'h0) ^ (8'h01 << k), ack);
			check(ack, 1'h1);
			ctl_u.stop();
		end
		// Short writes, busy poll, read back; last one with a slow controller
		for (int j = 0; j < 4; j++)
		begin
			a = nxt() >> 3;
			n = (j == 0) ? 1 : 1 + int'(nxt() % 8);
			ctl_u.stretch = (j == 3) ? 3 : 0;
			we0 = we_cnt;
			wr_page(a, n);
			repeat (16) @(posedge clk);
			check(we_cnt - we0, n);
			check(standby, 1'h0);
			ctl_u.start();
			ctl_u.put(dev(1'h0), ack);
			check(ack, 1'h1);
			ctl_u.stop();
			wait_idle();
			rd_seq(a, n);
		end
		ctl_u.stretch = 0;
		// Current-address read continues after the last byte read
		ctl_u.start();
		ctl_u.put(dev(1'h1), ack);
		ctl_u.get(1'h0, d);
		ctl_u.stop();
		check(d, exp_q[a + n[15:0]]);
		repeat (10) @(posedge clk);
		check(standby, 1'h1);
		// Overlong page write wraps inside the page
		a = {9'(nxt()), 7'h7E};
		wr_page(a, 130);
		wait_idle();
		rd_seq({a[15:7], 7'h00}, 128);
		rd_seq(16'hFFFF, 2);
		// Protected write: protocol completes, nothing stored
		wp <= 1'h1;
		repeat (4) @(posedge clk);
		we0 = we_cnt;
		a = nxt() >> 9;
		wr_page(a, 3);
		repeat (16) @(posedge clk);
		check(we_cnt, we0);
		check(standby, 1'h1);
		rd_seq(a, 3);
		wp <= 1'h0;
		// Stop in mid-byte writes nothing, not even the complete byte before it
		hdr(a);
		ctl_u.put(8'h5A, ack);
		check(ack, 1'h0);
		for (int i = 0; i < 4; i++)
			ctl_u.bit_cyc(1'h0, ack);
		ctl_u.stop();
		repeat (16) @(posedge clk);
		check(we_cnt, we0);
		// Protocol reset sequence, then a normal read
		ctl_u.start();
		for (int i = 0; i < 9; i++)
			ctl_u.bit_cyc(1'h1, ack);
		ctl_u.start();
		ctl_u.stop();
		rd_seq(nxt() >> 4, 3);
		complete_run();
	end

	// Hang guard
	initial
	begin
		repeat (90000) @(posedge clk);
		errors++;
		complete_run();
	end
endmodule
